// ---- core/watchdog_memory_control.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Unmapped addresses read zero, writes ignored
// - Two 16-bit pointer banks at 82H-85H
// - Bank select bit picks active pointer
// - Power-off flag bit 4, survives reset
// - Control register at 96H, resets to 02H
// - Prescale bits 7..5: 16 ms to 2048 ms
// - Access enable routes pointer moves to EEPROM
// - Restart write makes one-shot restart pulse
// - Bit 1 reads ready/busy flag from EEPROM
// - Watchdog enable bit runs or stops timer
module watchdog_memory_control #(
  parameter longint WDOG_BASE_CYCLES = wdmc_pkg::WDOG_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Power-up marker, high for the first cycles after supply comes up
  input  wire logic        i_power_up,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // EEPROM engine status
  input  wire logic        i_ee_busy,
  // Pointer and memory control to the core
  output logic      [15:0] o_active_pointer,
  output logic             o_eeprom_access_enable,
  output logic             o_eeprom_write_enable,
  // System reset and interrupt
  output logic             o_system_reset,
  output logic             o_irq
);
  wdmc_pkg::reg_req_t req;                 // Bundled bus request
  logic [7:0]  ptr_reg [4];                // Pointer bytes: bank0 lo/hi, bank1 lo/hi
  logic [7:0]  wmc_reg;                    // Control register, bit 1 unused as storage
  logic        restart_reg;                // One-cycle restart pulse
  logic        pwr_off_reg;                // Power-off flag
  logic [3:0]  pwr_low_reg;                // Other power control bits
  logic [wdmc_pkg::IRQ_WIDTH-1:0] stat_reg; // Sticky event bits
  logic [wdmc_pkg::IRQ_WIDTH-1:0] mask_reg; // Interrupt mask
  logic        ee_busy_s1_reg;             // Synchroniser stage one
  logic        ee_busy_s2_reg;             // Synchroniser stage two
  logic        ee_busy_d_reg;              // Previous busy for edge detection
  logic        wdog_expire;                // Timer expiry pulse
  logic        pwr_up_s1_reg;              // Power-up synchroniser stage one
  logic        pwr_up_s2_reg;              // Power-up synchroniser stage two

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Address decode
  wire hit_wmc   = (req.addr == wdmc_pkg::ADDR_WMC);
  wire hit_pwr   = (req.addr == wdmc_pkg::ADDR_PWR_CTRL);
  wire hit_stat  = (req.addr == wdmc_pkg::ADDR_IRQ_STAT);
  wire hit_mask  = (req.addr == wdmc_pkg::ADDR_IRQ_MASK);
  wire wr_wmc    = req.wr && hit_wmc;
  wire wr_pwr    = req.wr && hit_pwr;
  wire wr_stat   = req.wr && hit_stat;
  wire wr_mask   = req.wr && hit_mask;
  wire bank_sel  = wmc_reg[wdmc_pkg::WMC_BANK_SEL_BIT];
  wire ee_ready  = !ee_busy_s2_reg;
  wire ee_done   = ee_busy_d_reg && !ee_busy_s2_reg;
  // Any register at all; used to spot unmapped reads
  wire hit_ptr   = (req.addr >= wdmc_pkg::ADDR_PTR0_LO) && (req.addr <= wdmc_pkg::ADDR_PTR1_HI);
  wire hit_any   = hit_ptr || hit_wmc || hit_pwr || hit_stat || hit_mask;

  // Events that set sticky status bits
  wire [wdmc_pkg::IRQ_WIDTH-1:0] events = {ee_done, wdog_expire};

  // Read view of control register: bit 1 shows ready/busy
  wire [7:0] wmc_view = {wmc_reg[7:2], ee_ready, wmc_reg[0]};

  // Read data selection; unmapped gives zero
  wire [7:0] rd_mux =
    (req.addr == wdmc_pkg::ADDR_PTR0_LO) ? ptr_reg[0] :
    (req.addr == wdmc_pkg::ADDR_PTR0_HI) ? ptr_reg[1] :
    (req.addr == wdmc_pkg::ADDR_PTR1_LO) ? ptr_reg[2] :
    (req.addr == wdmc_pkg::ADDR_PTR1_HI) ? ptr_reg[3] :
    hit_pwr  ? {3'h0, pwr_off_reg, pwr_low_reg} :
    hit_wmc  ? wmc_view :
    hit_stat ? {6'h00, stat_reg} :
    hit_mask ? {6'h00, mask_reg} :
    wdmc_pkg::UNMAPPED_DATA;

  // Pointer banks: one byte register per address
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ptr
      wire hit = (req.addr == wdmc_pkg::ADDR_PTR0_LO + 8'(gi));
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          ptr_reg[gi] <= wdmc_pkg::PTR_RESET;
        end else if (req.wr && hit) begin
          ptr_reg[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  // Control register; restart bit is write-only and not stored
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wmc_reg     <= wdmc_pkg::WMC_RESET;
      restart_reg <= 1'b0;
    end else begin
      if (wr_wmc) begin
        wmc_reg <= {req.wdata[7:2], 1'b1, req.wdata[0]};
      end
      restart_reg <= wr_wmc && req.wdata[wdmc_pkg::WMC_RESTART_BIT];
    end
  end

  // Power-up marker comes from the supply monitor, so it is synchronised;
  // no reset here, since reset must never reach the flag path.
  // Limitation: the marker must stay high for at least one full clock cycle
  always_ff @(posedge i_clk) begin
    pwr_up_s1_reg <= i_power_up;
    pwr_up_s2_reg <= pwr_up_s1_reg;
  end

  // Power-off flag: only power-up or software touch it, not reset
  always_ff @(posedge i_clk) begin
    if (pwr_up_s2_reg) begin
      pwr_off_reg <= 1'b1;
    end else if (wr_pwr) begin
      pwr_off_reg <= req.wdata[wdmc_pkg::PWR_OFF_FLAG_BIT];
    end
  end

  // Remaining power control bits reset normally
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pwr_low_reg <= wdmc_pkg::PWR_RESET[3:0];
    end else if (wr_pwr) begin
      pwr_low_reg <= req.wdata[3:0];
    end
  end

  // Busy input crosses from the EEPROM engine; two stages first
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ee_busy_s1_reg <= 1'b0;
      ee_busy_s2_reg <= 1'b0;
      ee_busy_d_reg  <= 1'b0;
    end else begin
      ee_busy_s1_reg <= i_ee_busy;
      ee_busy_s2_reg <= ee_busy_s1_reg;
      ee_busy_d_reg  <= ee_busy_s2_reg;
    end
  end

  // Sticky status: set wins over write-one-to-clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_stat ? req.wdata[1:0] : 2'h0)) | events;
      if (wr_mask) begin
        mask_reg <= req.wdata[1:0];
      end
    end
  end

  // Watchdog timer
  wdog_timer #(
    .BASE_CYCLES (WDOG_BASE_CYCLES)
  ) u_wdog (
    .i_clk      (i_clk),
    .i_resetn   (i_resetn),
    .i_enable   (wmc_reg[wdmc_pkg::WMC_WDOG_EN_BIT]),
    .i_restart  (restart_reg),
    .i_prescale (wmc_reg[7:wdmc_pkg::WMC_PRESCALE_LSB]),
    .o_expire   (wdog_expire)
  );

  // Registered outputs
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata                <= 8'h00;
      o_active_pointer       <= 16'h0000;
      o_eeprom_access_enable <= 1'b0;
      o_eeprom_write_enable  <= 1'b0;
      o_system_reset         <= 1'b0;
      o_irq                  <= 1'b0;
    end else begin
      o_rdata                <= req.rd ? rd_mux : 8'h00;
      // Active pointer follows the bank select
      o_active_pointer       <= bank_sel ? {ptr_reg[3], ptr_reg[2]}
                                         : {ptr_reg[1], ptr_reg[0]};
      o_eeprom_access_enable <= wmc_reg[wdmc_pkg::WMC_ACCESS_EN_BIT];
      o_eeprom_write_enable  <= wmc_reg[wdmc_pkg::WMC_WRITE_EN_BIT];
      o_system_reset         <= wdog_expire;
      o_irq                  <= |(stat_reg & mask_reg);
    end
  end

  // Software write that carries the restart bit
  sequence s_restart_write;
    wr_wmc && req.wdata[wdmc_pkg::WMC_RESTART_BIT];
  endsequence

  // Watchdog enable seen low on two edges in a row
  sequence s_wdog_idle;
    !wmc_reg[wdmc_pkg::WMC_WDOG_EN_BIT] ##1 !wmc_reg[wdmc_pkg::WMC_WDOG_EN_BIT];
  endsequence

  // Restart pulse lasts one cycle unless the control register is written again in the pulse cycle
  property p_restart_one;
    @(posedge i_clk) disable iff (!i_resetn)
      restart_reg |=> !restart_reg || $past(wr_wmc);
  endproperty
  a_restart_one: assert property (p_restart_one) else $error("restart pulse stuck");

  // Writing restart makes the pulse next cycle
  property p_restart_cause;
    @(posedge i_clk) disable iff (!i_resetn)
      s_restart_write |=> restart_reg;
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("no restart pulse");

  // Bank select drives the active pointer
  property p_bank;
    @(posedge i_clk) disable iff (!i_resetn)
      ##1 o_active_pointer == ($past(bank_sel) ? $past({ptr_reg[3], ptr_reg[2]})
                                                : $past({ptr_reg[1], ptr_reg[0]}));
  endproperty
  a_bank: assert property (p_bank) else $error("wrong pointer bank");

  // Ready bit in a read follows the busy input two sync stages back
  property p_ready;
    @(posedge i_clk) disable iff (!i_resetn)
      (req.rd && hit_wmc) |=> o_rdata[wdmc_pkg::WMC_RESTART_BIT] == !$past(i_ee_busy, 3);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");

  // Any unmapped read returns the fixed filler byte
  property p_unmapped;
    @(posedge i_clk) disable iff (!i_resetn)
      (req.rd && !hit_any) |=> o_rdata == wdmc_pkg::UNMAPPED_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  // Disabled watchdog never resets system
  property p_wdog_off;
    @(posedge i_clk) disable iff (!i_resetn)
      s_wdog_idle |=> !o_system_reset;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("reset while disabled");

  // System reset only follows expiry
  property p_sys_reset;
    @(posedge i_clk) disable iff (!i_resetn)
      o_system_reset |-> $past(wdog_expire);
  endproperty
  a_sys_reset: assert property (p_sys_reset) else $error("spurious system reset");

  // Power-off flag written value sticks
  property p_pof;
    @(posedge i_clk)
      (wr_pwr && !pwr_up_s2_reg) |=> pwr_off_reg == $past(req.wdata[wdmc_pkg::PWR_OFF_FLAG_BIT]);
  endproperty
  a_pof: assert property (p_pof) else $error("power-off flag wrong");

  // Reset alone never moves the power-off flag
  property p_pof_hold;
    @(posedge i_clk)
      (!i_resetn && !pwr_up_s2_reg && !wr_pwr) |=> $stable(pwr_off_reg);
  endproperty
  a_pof_hold: assert property (p_pof_hold) else $error("power-off flag lost in reset");

  // Control register comes out of reset at its fixed value
  property p_wmc_reset;
    @(posedge i_clk)
      !i_resetn |=> wmc_reg == wdmc_pkg::WMC_RESET;
  endproperty
  a_wmc_reset: assert property (p_wmc_reset) else $error("control reset value wrong");

  // Access enable output follows its control bit one edge later
  property p_access;
    @(posedge i_clk) disable iff (!i_resetn)
      ##1 o_eeprom_access_enable == $past(wmc_reg[wdmc_pkg::WMC_ACCESS_EN_BIT]);
  endproperty
  a_access: assert property (p_access) else $error("access enable wrong");

  // End of programming always lands in status, even beside a clear
  property p_ee_done;
    @(posedge i_clk) disable iff (!i_resetn)
      $fell(ee_busy_s2_reg) |=> stat_reg[wdmc_pkg::IRQ_EE_DONE_BIT];
  endproperty
  a_ee_done: assert property (p_ee_done) else $error("programming end not flagged");

  // Expiry always lands in status, even beside a clear
  property p_wdog_status;
    @(posedge i_clk) disable iff (!i_resetn)
      wdog_expire |=> stat_reg[wdmc_pkg::IRQ_WDOG_BIT];
  endproperty
  a_wdog_status: assert property (p_wdog_status) else $error("expiry not flagged");
endmodule

// ---- core/wdmc_pkg.sv ----
package wdmc_pkg;
  // Register addresses on the special function bus
  localparam logic [7:0] ADDR_PTR0_LO   = 8'h82;
  localparam logic [7:0] ADDR_PTR0_HI   = 8'h83;
  localparam logic [7:0] ADDR_PTR1_LO   = 8'h84;
  localparam logic [7:0] ADDR_PTR1_HI   = 8'h85;
  localparam logic [7:0] ADDR_PWR_CTRL  = 8'h87;
  localparam logic [7:0] ADDR_WMC       = 8'h96;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'hA1;
  // Reset values and unmapped read data
  localparam logic [7:0] WMC_RESET      = 8'h02;
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] PWR_RESET      = 8'h10;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
  // Field positions in the watchdog and memory control register and the power control register
  localparam int WMC_PRESCALE_LSB       = 5;
  localparam int WMC_WRITE_EN_BIT       = 4;
  localparam int WMC_ACCESS_EN_BIT      = 3;
  localparam int WMC_BANK_SEL_BIT       = 2;
  localparam int WMC_RESTART_BIT        = 1;
  localparam int WMC_WDOG_EN_BIT        = 0;
  localparam int PWR_OFF_FLAG_BIT       = 4;
  // Interrupt status bits
  localparam int IRQ_WDOG_BIT           = 0;
  localparam int IRQ_EE_DONE_BIT        = 1;
  localparam int IRQ_WIDTH              = 2;
  // Watchdog timing: base period and clock rate
  localparam longint WDOG_BASE_MS       = 16;
  localparam longint CLK_HZ             = 200000000;
  localparam longint WDOG_BASE_CYCLES   = WDOG_BASE_MS * CLK_HZ / 1000;
  localparam int     WDOG_CNT_W         = 40;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
endpackage

// ---- core/wdog_timer.sv ----
`timescale 1ns/1ps
// Watchdog counter: period doubles per prescale step
module wdog_timer #(
  parameter longint BASE_CYCLES = wdmc_pkg::WDOG_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Control
  input  wire logic       i_enable,
  input  wire logic       i_restart,
  input  wire logic [2:0] i_prescale,
  // Expiry pulse
  output logic            o_expire
);
  // Local copy keeps the size cast below free of a scoped name
  localparam int CNT_W = wdmc_pkg::WDOG_CNT_W;
  logic [wdmc_pkg::WDOG_CNT_W-1:0] count_reg;   // Cycles since restart
  wire  [wdmc_pkg::WDOG_CNT_W-1:0] limit;       // Current period in cycles
  wire                             at_limit;    // Period elapsed

  // Each prescale step doubles the period
  assign limit    = CNT_W'(BASE_CYCLES) << i_prescale;
  assign at_limit = (count_reg >= limit - 1'b1);

  // Counter: held clear while disabled or restarted
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_enable || i_restart) begin
      count_reg <= '0;
      o_expire  <= 1'b0;
    end else if (at_limit) begin
      count_reg <= '0;
      o_expire  <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      o_expire  <= 1'b0;
    end
  end
endmodule

// ---- testbench/watchdog_memory_control_bench.sv ----
`timescale 1ns/1ps
module watchdog_memory_control_bench;
  // Short base period so the three tested prescale steps fit in a brief run
  localparam longint BASE = 8;
  // One table row: write a byte, then expect this read-back
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } row_t;
  logic        i_clk      = 1'b0;
  logic        i_resetn   = 1'b0;
  logic        i_power_up = 1'b1;
  logic [7:0]  i_addr     = 8'h00;
  logic [7:0]  i_wdata    = 8'h00;
  logic        i_wr       = 1'b0;
  logic        i_rd       = 1'b0;
  logic        i_ee_busy  = 1'b0;
  logic [7:0]  o_rdata;
  logic [15:0] o_active_pointer;
  logic        o_eeprom_access_enable;
  logic        o_eeprom_write_enable;
  logic        o_system_reset;
  logic        o_irq;
  int          miscompares = 0;
  int          checked     = 0;
  int          cyc         = 0;   // Free-running cycle count
  int          pulses      = 0;   // System reset pulses seen
  int          t_last      = 0;   // Cycle of the latest pulse
  int          t_prev      = 0;   // Cycle of the pulse before it
  int          n0;
  int          k;
  // Ordinary cases; the unmapped row must read back zero
  row_t        rows [8] = '{
    '{8'h82, 8'hA5, 8'hA5}, '{8'h83, 8'h5A, 8'h5A}, '{8'h84, 8'hC3, 8'hC3},
    '{8'h85, 8'h3C, 8'h3C}, '{8'h87, 8'h1F, 8'h1F}, '{8'h87, 8'h0A, 8'h0A},
    '{8'h40, 8'h77, 8'h00}, '{8'h96, 8'h1C, 8'h1E}};

  watchdog_memory_control #(
    .WDOG_BASE_CYCLES(BASE)
  ) i_watchdog_memory_control (
    .i_clk                  (i_clk),
    .i_resetn               (i_resetn),
    .i_power_up             (i_power_up),
    .i_addr                 (i_addr),
    .i_wdata                (i_wdata),
    .i_wr                   (i_wr),
    .i_rd                   (i_rd),
    .o_rdata                (o_rdata),
    .i_ee_busy              (i_ee_busy),
    .o_active_pointer       (o_active_pointer),
    .o_eeprom_access_enable (o_eeprom_access_enable),
    .o_eeprom_write_enable  (o_eeprom_write_enable),
    .o_system_reset         (o_system_reset),
    .o_irq                  (o_irq)
  );

  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;

  // Pulse monitor; non-blocking so readers never race the edge
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_system_reset === 1'b1) begin
      pulses <= pulses + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  // Write cycle; the idle edge after it keeps strobes single-driven
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    @(posedge i_clk);
  endtask

  // Read cycle; data only stand in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
    chk_byte("read data", e, d);
    @(posedge i_clk);
  endtask

  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard: the tests need well under 2000 cycles
  initial begin
    repeat (8000) @(posedge i_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_resetn   <= 1'b1;
    i_power_up <= 1'b0;
    rchk(wdmc_pkg::ADDR_WMC, wdmc_pkg::WMC_RESET);
    rchk(wdmc_pkg::ADDR_PWR_CTRL, wdmc_pkg::PWR_RESET);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rchk(rows[i].addr, rows[i].rexp);
    end
    $display("test table done");
    // Bank select is 1 from the last row; outputs are read once settled
    #1;
    chk_word("active pointer", 16'h3CC3, o_active_pointer);
    chk_bit("access enable", 1'b1, o_eeprom_access_enable);
    chk_bit("write enable", 1'b1, o_eeprom_write_enable);
    @(posedge i_clk);
    // Bank select is cleared before the pointer is looked at
    wr(wdmc_pkg::ADDR_WMC, 8'h00);
    #1;
    chk_word("active pointer", 16'h5AA5, o_active_pointer);
    chk_bit("access enable", 1'b0, o_eeprom_access_enable);
    @(posedge i_clk);
    $display("test bank select done");
    // Flag must survive a mid-run reset while low bits clear
    wr(wdmc_pkg::ADDR_PWR_CTRL, 8'h13);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    rchk(wdmc_pkg::ADDR_PWR_CTRL, 8'h10);
    rchk(wdmc_pkg::ADDR_PTR1_HI, 8'h00);
    rchk(wdmc_pkg::ADDR_WMC, 8'h02);
    $display("test reset done");
    // Period per prescale step; third pulse avoids the change-over
    wr(wdmc_pkg::ADDR_IRQ_MASK, 8'h01);
    for (int p = 0; p < 3; p++) begin
      wr(wdmc_pkg::ADDR_WMC, {3'(p), 5'h03});
      n0 = pulses;
      k  = 0;
      while (pulses < n0 + 3 && k < 400) begin
        @(posedge i_clk);
        k++;
      end
      chk_word("watchdog period", 16'(BASE << p), 16'(t_last - t_prev));
    end
    chk_bit("irq on expiry", 1'b1, o_irq);
    $display("test period done");
    // Restarts every two cycles must hold off expiry
    wr(wdmc_pkg::ADDR_WMC, 8'h03);
    wr(wdmc_pkg::ADDR_WMC, 8'h03);
    n0 = pulses;
    repeat (8) wr(wdmc_pkg::ADDR_WMC, 8'h03);
    chk_word("pulses while restarting", 16'(n0), 16'(pulses));
    // Disabled timer stays silent
    wr(wdmc_pkg::ADDR_WMC, 8'h00);
    repeat (4) @(posedge i_clk);
    wr(wdmc_pkg::ADDR_IRQ_STAT, 8'h01);
    n0 = pulses;
    repeat (40) @(posedge i_clk);
    chk_word("pulses while disabled", 16'(n0), 16'(pulses));
    chk_bit("irq cleared", 1'b0, o_irq);
    $display("test restart and enable done");
    // Write enable first, then programming reads busy and its end raises irq
    wr(wdmc_pkg::ADDR_IRQ_MASK, 8'h02);
    wr(wdmc_pkg::ADDR_WMC, 8'h10);
    i_ee_busy <= 1'b1;
    repeat (4) @(posedge i_clk);
    rchk(wdmc_pkg::ADDR_WMC, 8'h10);
    i_ee_busy <= 1'b0;
    repeat (4) @(posedge i_clk);
    rchk(wdmc_pkg::ADDR_WMC, 8'h12);
    chk_bit("irq on done", 1'b1, o_irq);
    rchk(wdmc_pkg::ADDR_IRQ_STAT, 8'h02);
    wr(wdmc_pkg::ADDR_IRQ_STAT, 8'h02);
    @(posedge i_clk);
    chk_bit("irq after clear", 1'b0, o_irq);
    // Write enable dropped once programming has finished
    wr(wdmc_pkg::ADDR_WMC, 8'h00);
    #1;
    chk_bit("write enable", 1'b0, o_eeprom_write_enable);
    $display("test ready flag done");
    wrap_up();
  end
endmodule
